// File: bench/ulpm_assertions.sv
`timescale 1ns/1ps
// ========================================
// pin-level checker for the mode block
module ulpm_assertions (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // register port
    input wire logic [ulpm_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [ulpm_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input logic [ulpm_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // link side bus
    input wire logic [7:0] ULPI_DATA_IN,
    input logic [7:0] ULPI_DATA_OUT,
    input logic [7:0] ULPI_DATA_OE_OUT,
    input wire logic ULPI_STP_IN,
    input logic ULPI_DIR_OUT,
    input logic ULPI_NXT_OUT,
    // analog side
    input wire logic [1:0] LINE_STATE_IN,
    input wire logic DIFFERENTIAL_RX_IN,
    input wire logic RX_SE0_IN,
    input logic TX_ENABLE_OUT,
    input logic SERIAL_TX_DIFF_DATA_OUT,
    input logic SERIAL_TX_SINGLE_ENDED_ZERO_OUT,
    input logic IRQ_OUT
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    AST_NXT_UNUSED: assert property (!ULPI_NXT_OUT)
        else $error("next strobe raised");
    AST_RDATA_QUIET: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
        else $error("read data outside its cycle");
    // two cycles of full drive only happen in low power, the status byte is single
    AST_LOW_MAP: assert property ((ULPI_DIR_OUT && ULPI_DATA_OE_OUT == 8'hFF) [*2] |->
        ULPI_DATA_OUT == {4'h0, IRQ_OUT, 1'b0, LINE_STATE_IN})
        else $error("low power bus map wrong");
    AST_SER3_RX: assert property ((ULPI_DIR_OUT && ULPI_DATA_OE_OUT == 8'hFE) |->
        ULPI_DATA_OUT[7:1] == {4'h0, IRQ_OUT, RX_SE0_IN, DIFFERENTIAL_RX_IN})
        else $error("three wire receive map wrong");
    AST_SER_UPPER: assert property ((ULPI_DIR_OUT && ULPI_DATA_OE_OUT == 8'hF8) |->
        ULPI_DATA_OUT[3] == IRQ_OUT && !ULPI_DATA_OUT[7])
        else $error("serial interrupt line or line 7 wrong");
    AST_TX_OWNER: assert property (TX_ENABLE_OUT |-> ULPI_DATA_IN[0] && ULPI_DIR_OUT && ULPI_DATA_OE_OUT[2:0] == 3'h0)
        else $error("transmit while device owns tx lines");
    AST_TX_BITS: assert property (SERIAL_TX_DIFF_DATA_OUT == (TX_ENABLE_OUT && ULPI_DATA_IN[1]) &&
        SERIAL_TX_SINGLE_ENDED_ZERO_OUT == (TX_ENABLE_OUT && ULPI_DATA_IN[2]))
        else $error("transmit bits not gated by enable");
    AST_LOW_ENTRY: assert property (REG_WR_IN && REG_ADDR_IN == ulpm_pkg::FUNCTION_CONTROL_REG_ADDR && !REG_WDATA_IN[0] &&
        !ULPI_DIR_OUT && !$past(ULPI_DIR_OUT) |-> ##[1:3] ULPI_DIR_OUT && ULPI_DATA_OE_OUT == 8'hFF)
        else $error("low power not entered");
    AST_SIX_ENTRY: assert property (REG_WR_IN && REG_ADDR_IN == ulpm_pkg::INTERFACE_CONTROL_REG_ADDR && REG_WDATA_IN[0] &&
        !ULPI_DIR_OUT && !$past(ULPI_DIR_OUT) |-> ##[1:3] ULPI_DIR_OUT && ULPI_DATA_OE_OUT == 8'hF8)
        else $error("six wire mode not entered");
    AST_THREE_ENTRY: assert property (REG_WR_IN && REG_ADDR_IN == ulpm_pkg::INTERFACE_CONTROL_REG_ADDR &&
        REG_WDATA_IN[1:0] == 2'b10 && !ULPI_DIR_OUT && !$past(ULPI_DIR_OUT) |->
        ##[1:3] ULPI_DIR_OUT && ULPI_DATA_OE_OUT[7:3] == 5'h1F && !ULPI_DATA_OE_OUT[0])
        else $error("three wire mode not entered");
    AST_WAKE_RELEASE: assert property ((ULPI_DIR_OUT && ULPI_STP_IN) [*6] |-> ULPI_DATA_OE_OUT == 8'h00)
        else $error("bus still driven while stop held");
    AST_EXIT: assert property ((ULPI_DIR_OUT && ULPI_STP_IN) [*4] ##1 !ULPI_STP_IN |->
        ##[1:6] !ULPI_DIR_OUT)
        else $error("bus not returned after stop");
endmodule

bind ulpm_top ulpm_assertions ulpm_assertions_i (.CLK_IN, .RSTN_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
    .REG_RD_IN, .REG_RDATA_OUT, .ULPI_DATA_IN, .ULPI_DATA_OUT, .ULPI_DATA_OE_OUT, .ULPI_STP_IN, .ULPI_DIR_OUT,
    .ULPI_NXT_OUT, .LINE_STATE_IN, .DIFFERENTIAL_RX_IN, .RX_SE0_IN, .TX_ENABLE_OUT, .SERIAL_TX_DIFF_DATA_OUT,
    .SERIAL_TX_SINGLE_ENDED_ZERO_OUT, .IRQ_OUT);

// File: bench/ulpm_link_model.sv
`timescale 1ns/1ps
// ========================================
// link controller facing the data bus
module ulpm_link_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // device drive
    input wire logic dir_in,
    input wire logic [7:0] dev_data_in,
    input wire logic [7:0] dev_oe_in,
    // scenario control
    input wire logic serial_in,
    input wire logic six_in,
    input wire logic [2:0] tx_in, // {se0, diff, enable}
    input wire logic stp_req_in,
    // resolved wire levels
    output logic [7:0] bus_out,
    output logic stp_out
);
    logic [7:0] link_oe; // lines the link drives
    logic [7:0] float_reg; // undriven lines toggle so no stale value passes

    // ========================================
    // floating pattern
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            float_reg <= 8'h5A;
        end else begin
            float_reg <= ~float_reg;
        end
    end

    // ========================================
    // which lines the link owns
    always_comb begin
        if (!dir_in) begin
            link_oe = 8'hFF; // idle zero while the link owns the bus
        end else if (serial_in && (six_in || tx_in[0])) begin
            link_oe = 8'h07;
        end else if (serial_in) begin
            link_oe = 8'h01;
        end else begin
            link_oe = 8'h00;
        end
    end

    // device drive wins, then link, else floating
    assign bus_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & link_oe & {5'h0, tx_in & {3{dir_in}}})
        | (~dev_oe_in & ~link_oe & float_reg);
    // held exactly as long as the scenario asks, eight cycles in run_mode
    assign stp_out = stp_req_in;
endmodule

// File: bench/ulpm_top_bench.sv
`timescale 1ns/1ps
// ========================================
// self-checking bench for the mode block
module ulpm_top_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, dout, doe, din;
    logic stp, dir, nxt, irq, clk_stop;
    logic [1:0] ls = 2'h0; // line state
    logic [2:0] rxv = 3'h0; // {diff, minus, plus}
    logic se0_rx = 1'b0;
    logic [2:0] txo; // {se0, diff, enable}
    logic [3:0] src = 4'h0;
    logic serial = 1'b0;
    logic six = 1'b0;
    logic [2:0] tx = 3'h0;
    logic stp_req = 1'b0;
    logic irq_exp = 1'b0; // expected interrupt level
    logic [3:0] bit_v;
    int err_count = 0;
    int checked = 0;
    logic [3:0] regs [6] = '{ulpm_pkg::FUNCTION_CONTROL_REG_ADDR, ulpm_pkg::INTERFACE_CONTROL_REG_ADDR, ulpm_pkg::IRQ_STAT_ADDR,
        ulpm_pkg::IRQ_MASK_ADDR, ulpm_pkg::MODE_STAT_ADDR, 4'hF};
    logic [7:0] rstv [6] = '{ulpm_pkg::FUNCTION_CONTROL_REG_RST, ulpm_pkg::INTERFACE_CONTROL_REG_RST, 8'h00, 8'h00, 8'h00, 8'h00};

    always #5 clk = ~clk;

    ulpm_top ulpm_top_i (
        .CLK_IN(clk), .RSTN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .ULPI_DATA_IN(din), .ULPI_DATA_OUT(dout),
        .ULPI_DATA_OE_OUT(doe), .ULPI_STP_IN(stp), .ULPI_DIR_OUT(dir), .ULPI_NXT_OUT(nxt),
        .LINE_STATE_IN(ls), .PLUS_LINE_RX_IN(rxv[0]), .MINUS_LINE_RX_IN(rxv[1]),
        .DIFFERENTIAL_RX_IN(rxv[2]), .RX_SE0_IN(se0_rx), .TX_ENABLE_OUT(txo[0]),
        .SERIAL_TX_DIFF_DATA_OUT(txo[1]), .SERIAL_TX_SINGLE_ENDED_ZERO_OUT(txo[2]),
        .IRQ_SRC_IN(src), .IRQ_OUT(irq), .IFCLK_STOP_OUT(clk_stop));

    ulpm_link_model ulpm_link_model_i (
        .clk_in(clk), .rst_n_in(rst_n), .dir_in(dir), .dev_data_in(dout), .dev_oe_in(doe),
        .serial_in(serial), .six_in(six), .tx_in(tx), .stp_req_in(stp_req), .bus_out(din), .stp_out(stp));

    // ========================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, rdata});
    endtask

    task automatic wait_dir(input logic v);
        for (int n = 0; n < 20 && dir !== v; n++) step(1);
        if (dir !== v) begin
            chk("dir", {15'h0, v}, {15'h0, dir});
            complete_run();
        end
    endtask

    // {oe, data} the device must show, undriven data bits zero
    function automatic logic [15:0] exp_bus(input int m, input logic t, input logic i);
        case (m)
            0: return {8'hFF, 4'h0, i, 1'b0, ls};
            1: return {8'hF8, 1'b0, rxv, i, 3'h0};
            default: return t ? {8'hF8, 4'h0, i, 3'h0} : {8'hFE, 4'h0, i, se0_rx, rxv[2], 1'b0};
        endcase
    endfunction

    // m: 0 low power, 1 six wire, 2 three wire; k keeps the clock in serial modes
    task automatic run_mode(input int m, input logic k);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        serial <= (m != 0);
        six <= (m == 1);
        if (m == 0) wr_reg(ulpm_pkg::FUNCTION_CONTROL_REG_ADDR, 8'h00);
        else wr_reg(ulpm_pkg::INTERFACE_CONTROL_REG_ADDR, {5'h0, k, m == 2, m == 1});
        wait_dir(1'b1);
        chk("clock stop", {15'h0, m == 0 || !k}, {15'h0, clk_stop});
        repeat (16) begin
            @(posedge clk);
            ls <= 2'($urandom);
            rxv <= 3'($urandom);
            se0_rx <= 1'($urandom);
            tx <= 3'($urandom);
            #1;
            chk("bus map", exp_bus(m, tx[0], irq_exp), {doe, dout & doe});
            chk("tx out", {13'h0, (m != 0 && tx[0]) ? tx : 3'h0}, {13'h0, txo});
            chk("next", 16'h0000, {15'h0, nxt});
        end
        // a source change that persists through exit must be reported
        @(posedge clk);
        stp_req <= 1'b1;
        if (m == 0) src <= src ^ 4'h2;
        step(7);
        chk("wake oe", 16'h0000, {8'h00, doe});
        @(posedge clk);
        stp_req <= 1'b0;
        for (int n = 0; n < 8 && dir === 1'b1; n++) begin
            step(1);
            if (dir === 1'b1 && doe === 8'hFF) begin
                seen = 1'b1;
                chk("status byte", {8'h00, src, 2'b00, ls}, {8'h00, dout});
            end
        end
        wait_dir(1'b0);
        if (m == 0) chk("status byte sent", 16'h0001, {15'h0, seen});
        serial <= 1'b0;
        six <= 1'b0;
        rd_chk(ulpm_pkg::FUNCTION_CONTROL_REG_ADDR, 8'h01, "active bit restored");
        rd_chk(ulpm_pkg::INTERFACE_CONTROL_REG_ADDR, {5'h0, k, 2'b00}, "selects cleared");
        $display("test mode %0d done", m);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================
    // main sequence
    initial begin
        void'($urandom(32'h49D1));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // unmapped and read-only writes must leave nothing behind
        wr_reg(4'hF, 8'hFF);
        wr_reg(ulpm_pkg::MODE_STAT_ADDR, 8'hFF);
        for (int i = 0; i < 6; i++) rd_chk(regs[i], rstv[i], "reset value");
        $display("test registers done");
        // interrupt: raise, mask, clear, raise again
        bit_v = 4'h1 << $urandom_range(3, 0);
        wr_reg(ulpm_pkg::IRQ_MASK_ADDR, 8'h0F);
        @(posedge clk);
        src <= bit_v;
        step(5);
        rd_chk(ulpm_pkg::IRQ_STAT_ADDR, {4'h0, bit_v}, "status set");
        chk("irq unmasked", 16'h0001, {15'h0, irq});
        wr_reg(ulpm_pkg::IRQ_MASK_ADDR, 8'h00);
        step(2);
        chk("irq masked", 16'h0000, {15'h0, irq});
        wr_reg(ulpm_pkg::IRQ_MASK_ADDR, 8'h0F);
        wr_reg(ulpm_pkg::IRQ_STAT_ADDR, {4'h0, bit_v});
        step(2);
        chk("irq cleared", 16'h0000, {15'h0, irq});
        @(posedge clk);
        src <= 4'h0;
        step(5);
        chk("irq on falling source", 16'h0001, {15'h0, irq});
        irq_exp = 1'b1;
        $display("test interrupt done");
        run_mode(0, 1'b0);
        wr_reg(ulpm_pkg::IRQ_STAT_ADDR, 8'h0F);
        step(2);
        irq_exp = 1'b0;
        bit_v[0] = 1'($urandom);
        run_mode(1, bit_v[0]);
        run_mode(2, !bit_v[0]);
        complete_run();
    end
endmodule

// File: verilog/ulpm_pkg.sv
// ====================================================================
// constants shared by the low-power / serial mode block
// ====================================================================
package ulpm_pkg;

    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register indices
    localparam logic [3:0] FUNCTION_CONTROL_REG_ADDR = 4'h0;
    localparam logic [3:0] INTERFACE_CONTROL_REG_ADDR = 4'h1;
    localparam logic [3:0] IRQ_STAT_ADDR = 4'h2;
    localparam logic [3:0] IRQ_MASK_ADDR = 4'h3;
    localparam logic [3:0] MODE_STAT_ADDR = 4'h4;

    // field positions
    localparam int ACTIVE_BIT = 0;
    localparam int SIX_SEL_BIT = 0;
    localparam int THREE_SEL_BIT = 1;
    localparam int KEEP_CLK_BIT = 2;

    // reset values
    localparam logic [7:0] FUNCTION_CONTROL_REG_RST = 8'h01;
    localparam logic [7:0] INTERFACE_CONTROL_REG_RST = 8'h00;
    localparam logic [3:0] IRQ_RST = 4'h0;

    // interrupt sources
    localparam int SRC_W = 4;

    // data bus drive patterns
    localparam logic [7:0] OE_ALL = 8'hFF;
    localparam logic [7:0] OE_SIX = 8'hF8;
    localparam logic [7:0] OE_THREE_TX = 8'hF8;
    localparam logic [7:0] OE_THREE_RX = 8'hFE;
    localparam logic [7:0] OE_NONE = 8'h00;

    // mode controller states, gray along three-wire entry and the exit path without rxcmd
    typedef enum logic [2:0] {
        ST_SYNC = 3'h0,
        ST_LOW = 3'h1,
        ST_SER6 = 3'h3,
        ST_SER3 = 3'h2,
        ST_WAKE = 3'h6,
        ST_RXCMD = 3'h7,
        ST_BACK = 3'h4
    } ulpm_state_t;

    // drive applied to the link-facing pins
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
        logic dir;
        logic nxt;
    } ulpm_drive_t;

    // request to the analog serial transmitter
    typedef struct packed {
        logic enable;
        logic diff;
        logic se0;
    } ulpm_tx_t;

endpackage

// File: verilog/ulpm_top.sv
`timescale 1ns/1ps
// Overview of operation
// - stp exits low power, bus restored
// - rxcmd on exit if change persists
// - lines 0,1 carry raw line state
// - low power drives lines 2,7..4 low
// - line 3 is unmasked interrupt indicator
// - stp exits six-wire mode to synchronous
// - six-wire outputs plus, minus, diff, line7 low
// - stp exits three-wire mode to synchronous
// - line 1 shared by tx enable direction
// - line 2 shared se0 by tx enable
// - three-wire drives lines 7..4 low
// - next signal unused outside synchronous mode
module ulpm_top #(
    parameter int SRC_W = ulpm_pkg::SRC_W
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // register port
    input wire logic [ulpm_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [ulpm_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [ulpm_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // link side data bus
    input wire logic [7:0] ULPI_DATA_IN,
    output logic [7:0] ULPI_DATA_OUT,
    output logic [7:0] ULPI_DATA_OE_OUT,
    input wire logic ULPI_STP_IN,
    output logic ULPI_DIR_OUT,
    output logic ULPI_NXT_OUT,
    // analog receiver
    input wire logic [1:0] LINE_STATE_IN,
    input wire logic PLUS_LINE_RX_IN,
    input wire logic MINUS_LINE_RX_IN,
    input wire logic DIFFERENTIAL_RX_IN,
    input wire logic RX_SE0_IN,
    // analog transmitter
    output logic TX_ENABLE_OUT,
    output logic SERIAL_TX_DIFF_DATA_OUT,
    output logic SERIAL_TX_SINGLE_ENDED_ZERO_OUT,
    // interrupt sources and summary
    input wire logic [SRC_W-1:0] IRQ_SRC_IN,
    output logic IRQ_OUT,
    // clock control
    output logic IFCLK_STOP_OUT
);

    // ================================================================
    // local signals
    ulpm_pkg::ulpm_state_t state_reg; // mode controller state
    ulpm_pkg::ulpm_state_t state_next; // next mode state
    logic [7:0] function_control_reg_reg; // function control register
    logic [7:0] interface_control_reg_reg; // interface control register
    logic [SRC_W-1:0] irq_stat_reg; // sticky change flags
    logic [SRC_W-1:0] irq_mask_reg; // interrupt enables
    logic [SRC_W-1:0] src_meta_reg; // first sync stage
    logic [SRC_W-1:0] src_sync_reg; // second sync stage
    logic [SRC_W-1:0] src_prev_reg; // last sampled level
    logic [SRC_W-1:0] src_snap_reg; // level caught at mode entry
    logic [1:0] ls_meta_reg; // line state first stage
    logic [1:0] ls_sync_reg; // line state second stage
    logic [7:0] rxcmd_reg; // byte sent on wake
    logic [7:0] rdata_reg; // read data, one cycle late
    logic stp_meta_reg; // stp first stage
    logic stp_sync_reg; // stp second stage
    logic irq_any; // any unmasked flag
    logic wake_pending; // persisting change at exit
    logic exit_done; // hardware restores mode bits
    logic wr_func; // write to function control
    logic wr_intf; // write to interface control
    logic wr_stat; // write-one-to-clear on status
    logic wr_mask; // write to mask
    logic three_tx_en; // link owns shared lines
    ulpm_pkg::ulpm_drive_t drive; // pin drive bundle
    ulpm_pkg::ulpm_tx_t tx_req; // analog tx bundle

    // ================================================================
    // helpers
    // register decode used by every write path
    function automatic logic hit(
        input logic [ulpm_pkg::ADDR_W-1:0] addr,
        input logic [ulpm_pkg::ADDR_W-1:0] want
    );
        hit = (addr == want);
    endfunction

    assign wr_func = REG_WR_IN & hit(REG_ADDR_IN, ulpm_pkg::FUNCTION_CONTROL_REG_ADDR);
    assign wr_intf = REG_WR_IN & hit(REG_ADDR_IN, ulpm_pkg::INTERFACE_CONTROL_REG_ADDR);
    assign wr_stat = REG_WR_IN & hit(REG_ADDR_IN, ulpm_pkg::IRQ_STAT_ADDR);
    assign wr_mask = REG_WR_IN & hit(REG_ADDR_IN, ulpm_pkg::IRQ_MASK_ADDR);

    // ================================================================
    // input synchronisers
    // interrupt source, line state and stp pins pass two flops first
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
            ls_meta_reg <= 2'h0;
            ls_sync_reg <= 2'h0;
            stp_meta_reg <= 1'b0;
            stp_sync_reg <= 1'b0;
        end else begin
            src_meta_reg <= IRQ_SRC_IN;
            src_sync_reg <= src_meta_reg;
            ls_meta_reg <= LINE_STATE_IN;
            ls_sync_reg <= ls_meta_reg;
            stp_meta_reg <= ULPI_STP_IN;
            stp_sync_reg <= stp_meta_reg;
        end
    end

    // previous level for change detection
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            src_prev_reg <= '0;
        end else begin
            src_prev_reg <= src_sync_reg;
        end
    end

    // ================================================================
    // mode controller
    // entry by register bits, exit by stp held high then released
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ulpm_pkg::ST_SYNC: begin
                // serial selects checked first, six-wire wins a tie
                if (interface_control_reg_reg[ulpm_pkg::SIX_SEL_BIT]) begin
                    state_next = ulpm_pkg::ST_SER6;
                end else if (interface_control_reg_reg[ulpm_pkg::THREE_SEL_BIT]) begin
                    state_next = ulpm_pkg::ST_SER3;
                end else if (!function_control_reg_reg[ulpm_pkg::ACTIVE_BIT]) begin
                    state_next = ulpm_pkg::ST_LOW;
                end
            end
            ulpm_pkg::ST_LOW, ulpm_pkg::ST_SER6, ulpm_pkg::ST_SER3: begin
                // wake request; clock is assumed running again by now
                if (stp_sync_reg) begin
                    state_next = ulpm_pkg::ST_WAKE;
                end
            end
            ulpm_pkg::ST_WAKE: begin
                // wait for the link to release stp
                if (!stp_sync_reg) begin
                    if (wake_pending) begin
                        state_next = ulpm_pkg::ST_RXCMD;
                    end else begin
                        state_next = ulpm_pkg::ST_BACK;
                    end
                end
            end
            ulpm_pkg::ST_RXCMD: begin
                // one status byte, then hand the bus back
                state_next = ulpm_pkg::ST_BACK;
            end
            ulpm_pkg::ST_BACK: begin
                // turnaround cycle, then synchronous again
                state_next = ulpm_pkg::ST_SYNC;
            end
            default: begin
                // illegal code recovers to synchronous
                state_next = ulpm_pkg::ST_SYNC;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_reg <= ulpm_pkg::ST_SYNC;
        end else begin
            state_reg <= state_next;
        end
    end

    assign exit_done = (state_reg == ulpm_pkg::ST_BACK);

    // ================================================================
    // wake status capture
    // snapshot at entry; a change that has gone back needs no rxcmd
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            src_snap_reg <= '0;
        end else if (state_reg == ulpm_pkg::ST_SYNC) begin
            src_snap_reg <= src_sync_reg;
        end
    end

    assign wake_pending = |(src_sync_reg ^ src_snap_reg);

    // status byte: sources high, line state low
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rxcmd_reg <= 8'h00;
        end else if (state_reg == ulpm_pkg::ST_WAKE) begin
            rxcmd_reg <= {4'(src_sync_reg), 2'h0, ls_sync_reg};
        end
    end

    // ================================================================
    // control registers
    // hardware restore on exit overrides a software write that cycle
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            function_control_reg_reg <= ulpm_pkg::FUNCTION_CONTROL_REG_RST;
        end else if (exit_done) begin
            function_control_reg_reg[ulpm_pkg::ACTIVE_BIT] <= 1'b1;
        end else if (wr_func) begin
            function_control_reg_reg <= REG_WDATA_IN;
        end
    end

    // serial selects self-clear on exit, keep-clock is kept
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            interface_control_reg_reg <= ulpm_pkg::INTERFACE_CONTROL_REG_RST;
        end else if (exit_done) begin
            interface_control_reg_reg[ulpm_pkg::SIX_SEL_BIT] <= 1'b0;
            interface_control_reg_reg[ulpm_pkg::THREE_SEL_BIT] <= 1'b0;
        end else if (wr_intf) begin
            interface_control_reg_reg <= REG_WDATA_IN;
        end
    end

    // ================================================================
    // interrupt flags
    // any edge on a source sets its flag; set beats a same-cycle clear
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            irq_stat_reg <= ulpm_pkg::IRQ_RST;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                            ~(wr_stat ? REG_WDATA_IN[SRC_W-1:0] : '0)) |
                            (src_sync_reg ^ src_prev_reg);
        end
    end

    // mask register
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            irq_mask_reg <= ulpm_pkg::IRQ_RST;
        end else if (wr_mask) begin
            irq_mask_reg <= REG_WDATA_IN[SRC_W-1:0];
        end
    end

    assign irq_any = |(irq_stat_reg & irq_mask_reg);
    assign IRQ_OUT = irq_any;

    // ================================================================
    // register read
    // unmapped reads return zero
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rdata_reg <= 8'h00;
        end else if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                ulpm_pkg::FUNCTION_CONTROL_REG_ADDR: rdata_reg <= function_control_reg_reg;
                ulpm_pkg::INTERFACE_CONTROL_REG_ADDR: rdata_reg <= interface_control_reg_reg;
                ulpm_pkg::IRQ_STAT_ADDR: rdata_reg <= 8'(irq_stat_reg);
                ulpm_pkg::IRQ_MASK_ADDR: rdata_reg <= 8'(irq_mask_reg);
                ulpm_pkg::MODE_STAT_ADDR: rdata_reg <= {4'(src_sync_reg), 1'b0, state_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign REG_RDATA_OUT = rdata_reg;

    // ================================================================
    // data bus mapping
    // link-driven line 0 decides who owns lines 1 and 2 in three-wire
    assign three_tx_en = ULPI_DATA_IN[0];

    // analog receiver values pass through unclocked in the alternate
    // modes; the link samples them asynchronously by definition
    always_comb begin
        drive.data = 8'h00;
        drive.oe = ulpm_pkg::OE_NONE;
        drive.dir = 1'b0;
        drive.nxt = 1'b0;
        unique case (state_reg)
            ulpm_pkg::ST_LOW: begin
                drive.dir = 1'b1;
                drive.oe = ulpm_pkg::OE_ALL;
                drive.data[1:0] = LINE_STATE_IN;
                drive.data[3] = irq_any;
            end
            ulpm_pkg::ST_SER6: begin
                // lines 0..2 stay inputs from the link
                drive.dir = 1'b1;
                drive.oe = ulpm_pkg::OE_SIX;
                drive.data[3] = irq_any;
                drive.data[4] = PLUS_LINE_RX_IN;
                drive.data[5] = MINUS_LINE_RX_IN;
                drive.data[6] = DIFFERENTIAL_RX_IN;
            end
            ulpm_pkg::ST_SER3: begin
                drive.dir = 1'b1;
                drive.data[3] = irq_any;
                if (three_tx_en) begin
                    drive.oe = ulpm_pkg::OE_THREE_TX;
                end else begin
                    drive.oe = ulpm_pkg::OE_THREE_RX;
                    drive.data[1] = DIFFERENTIAL_RX_IN;
                    drive.data[2] = RX_SE0_IN;
                end
            end
            ulpm_pkg::ST_WAKE: begin
                // bus released while stp is held, dir still high
                drive.dir = 1'b1;
            end
            ulpm_pkg::ST_RXCMD: begin
                drive.dir = 1'b1;
                drive.oe = ulpm_pkg::OE_ALL;
                drive.data = rxcmd_reg;
            end
            default: ; // synchronous mode and turnaround: listen only
        endcase
    end

    assign ULPI_DATA_OUT = drive.data;
    assign ULPI_DATA_OE_OUT = drive.oe;
    assign ULPI_DIR_OUT = drive.dir;
    assign ULPI_NXT_OUT = drive.nxt;

    // ================================================================
    // serial transmit request
    // only meaningful in the two serial modes, quiet otherwise
    always_comb begin
        tx_req.enable = 1'b0;
        tx_req.diff = 1'b0;
        tx_req.se0 = 1'b0;
        if ((state_reg == ulpm_pkg::ST_SER6) || (state_reg == ulpm_pkg::ST_SER3)) begin
            tx_req.enable = ULPI_DATA_IN[0];
            tx_req.diff = ULPI_DATA_IN[1] & ULPI_DATA_IN[0];
            tx_req.se0 = ULPI_DATA_IN[2] & ULPI_DATA_IN[0];
        end
    end

    assign TX_ENABLE_OUT = tx_req.enable;
    assign SERIAL_TX_DIFF_DATA_OUT = tx_req.diff;
    assign SERIAL_TX_SINGLE_ENDED_ZERO_OUT = tx_req.se0;

    // ================================================================
    // interface clock control
    // low power always may stop; serial only without keep-clock
    assign IFCLK_STOP_OUT = (state_reg == ulpm_pkg::ST_LOW) | (~interface_control_reg_reg[ulpm_pkg::KEEP_CLK_BIT] &
                            ((state_reg == ulpm_pkg::ST_SER6) | (state_reg == ulpm_pkg::ST_SER3)));

endmodule
